//--- design/idle_power_ctrl.sv
// power-state controller: clock-off idle state and deep power-off state
// assumes apb master on clk; async_in arrives from other domains and is synchronised here
`timescale 1ns/1ps

// Operation
// - idle state gates pll, buffer, fitter power
// - enter idle only if allowed and idle
// - pll off in idle state runs core clock from slow clock
// - leave idle on disallow or refresh activity
// - program must be loaded; cleared on resets
// - clear status flag, then clear enable
// - deep state entered when deep allow is set, left only when software clears it
// - deep state retains config and unit registers
module idle_power_ctrl
	import idle_power_pkg::*;
(
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic [31:0]                     prdata,
	// unsynchronised events and levels
	input  wire idle_power_pkg::async_in_t  async_in,
	// power and clock controls
	output idle_power_pkg::pwr_ctl_t        pwr_ctl,
	output logic                            save_ctx,
	output logic                            restore_ctx
);
	import idle_power_pkg::*;

	// ==========================================================
	// input synchronisers
	async_in_t sync1_ff;
	async_in_t sync2_ff;

	// two stages; only sync2_ff is read by logic
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= async_in;
			sync2_ff <= sync1_ff;
		end
	end

	// ==========================================================
	// apb decode
	wire         wr_en     = psel & penable & pwrite;
	wire         setup_rd  = psel & ~penable & ~pwrite;
	wire         hit_ctrl  = (paddr == CTRL_OFS);
	wire         hit_stat  = (paddr == STATUS_OFS);
	wire         hit_prog  = (paddr == PROG_OFS);
	wire         mapped    = hit_ctrl | hit_stat | hit_prog;
	wire         wr_ctrl   = wr_en & hit_ctrl;
	wire         wr_stat   = wr_en & hit_stat;
	wire         wr_prog   = wr_en & hit_prog;

	logic        co_en_ff;
	logic        deep_allow_ff;
	logic [1:0]  dyn_ff;
	logic        co_flag_ff;
	logic        loaded_ff;
	logic [11:0] exit_cnt_ff;
	pstate_t     state_ff;
	pstate_t     nxt_state;

	// zero-wait slave: answer in the first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	wire [31:0] stat_word = {25'h0, state_ff, 1'b0, (exit_cnt_ff != 12'h000), loaded_ff, co_flag_ff};
	wire [31:0] ctrl_word = {28'h0, dyn_ff, deep_allow_ff, co_en_ff};
	wire [31:0] rd_word   = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0000_0000);

	// read data captured in the setup cycle so it is a flop in the access cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			prdata <= 32'h0000_0000;
		else if (setup_rd)
			prdata <= rd_word;
	end

	// ==========================================================
	// control register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			co_en_ff      <= CTRL_RST[CO_EN_BIT];
			deep_allow_ff <= CTRL_RST[DEEP_ALLOW_BIT];
			dyn_ff        <= DYN_DISABLED;
		end else if (wr_ctrl) begin
			co_en_ff      <= pwdata[CO_EN_BIT];
			deep_allow_ff <= pwdata[DEEP_ALLOW_BIT];
			dyn_ff        <= pwdata[DYN_HI_BIT:DYN_LO_BIT];
		end
	end

	// ==========================================================
	// program-loaded flag and state flag
	// any reset source or deep power-off wipes the program; the load write loses to a wipe
	wire wipe_prog  = sync2_ff.warm_rst | sync2_ff.flr | sync2_ff.suspend | (state_ff == ST_DEEP);
	wire co_entry   = (nxt_state == ST_CO_IDLE) & (state_ff != ST_CO_IDLE);
	wire co_clr     = wr_stat & ~pwdata[CO_FLAG_BIT];
	wire nxt_loaded = wipe_prog ? 1'b0 : (wr_prog & pwdata[PROG_LOAD_BIT]) ? 1'b1 : loaded_ff;
	wire nxt_co_flag = co_entry | (co_flag_ff & ~co_clr);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loaded_ff  <= 1'b0;
			co_flag_ff <= 1'b0;
		end else begin
			loaded_ff  <= nxt_loaded;
			co_flag_ff <= nxt_co_flag;
		end
	end

	// ==========================================================
	// state machine
	// deep power-off takes priority; clock-off needs the loaded program
	wire co_ok = co_en_ff & loaded_ff & sync2_ff.ssr_idle;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_ACTIVE: begin
				if (deep_allow_ff)
					nxt_state = ST_SAVE;
				else if (co_ok)
					nxt_state = ST_CO_IDLE;
			end
			ST_CO_IDLE: begin
				if (!co_en_ff || !sync2_ff.ssr_idle || deep_allow_ff)
					nxt_state = ST_ACTIVE;
			end
			ST_SAVE: begin
				nxt_state = ST_DEEP;
			end
			ST_DEEP: begin
				if (!deep_allow_ff)
					nxt_state = ST_RESTORE;
			end
			ST_RESTORE: begin
				nxt_state = ST_ACTIVE;
			end
			default: begin
				nxt_state = ST_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			state_ff <= ST_ACTIVE;
		else
			state_ff <= nxt_state;
	end

	// ==========================================================
	// exit timer: status shows busy for the exit time after leaving clock-off
	// lets software poll instead of timing the wait itself
	wire co_exit = (state_ff == ST_CO_IDLE) & (nxt_state != ST_CO_IDLE);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			exit_cnt_ff <= 12'h000;
		else if (co_exit)
			exit_cnt_ff <= EXIT_CNT;
		else if (exit_cnt_ff != 12'h000)
			exit_cnt_ff <= exit_cnt_ff - 12'h001;
	end

	// ==========================================================
	// power outputs, registered from the next state so they switch with it
	pwr_ctl_t nxt_pwr;
	wire      nxt_co   = (nxt_state == ST_CO_IDLE);
	wire      nxt_deep = (nxt_state == ST_DEEP);

	always_comb begin
		nxt_pwr.cdclk_pll_en   = ~nxt_co & ~nxt_deep;
		nxt_pwr.cdclk_slow_sel = nxt_co;
		nxt_pwr.display_buffer_pwr_en    = ~nxt_co & ~nxt_deep;
		nxt_pwr.pfit_pwr_en    = ~nxt_co & ~nxt_deep;
		nxt_pwr.engine_pwr_en  = ~nxt_deep;
		nxt_pwr.cfg_retain     = (nxt_state == ST_SAVE) | nxt_deep | (nxt_state == ST_RESTORE);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_ctl     <= PWR_RST;
			save_ctx    <= 1'b0;
			restore_ctx <= 1'b0;
		end else begin
			pwr_ctl     <= nxt_pwr;
			save_ctx    <= (nxt_state == ST_SAVE);
			restore_ctx <= (nxt_state == ST_RESTORE);
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_deep_req;
		(state_ff == ST_ACTIVE) && deep_allow_ff;
	endsequence
	sequence s_deep_walk;
		##1 save_ctx ##1 (state_ff == ST_DEEP) && !pwr_ctl.engine_pwr_en;
	endsequence

	a_idle_power_off: assert property ((state_ff == ST_CO_IDLE) |->
		(!pwr_ctl.cdclk_pll_en && !pwr_ctl.display_buffer_pwr_en && !pwr_ctl.pfit_pwr_en))
		else $error("idle state left pll or buffer powered");
	a_idle_entry_gate: assert property ((state_ff != ST_CO_IDLE) ##1 (state_ff == ST_CO_IDLE) |->
		$past(co_en_ff) && $past(sync2_ff.ssr_idle) && $past(loaded_ff))
		else $error("idle state entered without permission");
	a_slow_clock_sel: assert property (!pwr_ctl.cdclk_pll_en && pwr_ctl.engine_pwr_en |-> pwr_ctl.cdclk_slow_sel)
		else $error("pll off without slow clock");
	a_idle_exit: assert property ((state_ff == ST_CO_IDLE) && !co_en_ff |=> (state_ff == ST_ACTIVE))
		else $error("idle state not left after disallow");
	a_prog_wipe: assert property ((state_ff == ST_DEEP) |=> !loaded_ff)
		else $error("program survived deep power-off");
	a_flag_hold: assert property (co_flag_ff && !co_clr |=> co_flag_ff)
		else $error("status flag lost without zero write");
	a_flag_set: assert property (co_entry |=> co_flag_ff)
		else $error("status flag not set on entry");
	a_deep_entry: assert property (s_deep_req |-> s_deep_walk)
		else $error("deep power-off entry sequence broken");
	a_deep_retain: assert property ((state_ff == ST_DEEP) |-> pwr_ctl.cfg_retain)
		else $error("config retention dropped in deep state");
	a_exit_timer: assert property (co_exit |=> (exit_cnt_ff == EXIT_CNT) ##1 (exit_cnt_ff == EXIT_CNT - 12'h001))
		else $error("exit timer not loaded");
	a_clear_then_exit: assert property (wr_ctrl && !pwdata[CO_EN_BIT] && (state_ff == ST_CO_IDLE) |-> ##2
		(state_ff != ST_CO_IDLE))
		else $error("idle state not left after enable cleared");
endmodule // idle_power_ctrl

//--- design/idle_power_pkg.sv
// shared constants and carrier types for the display idle power-state controller
// assumes a 20 MHz register clock and a 32-bit apb register bus
package idle_power_pkg;
	// ==========================================================
	// register map (byte offsets)
	localparam logic [11:0] CTRL_OFS      = 12'h000;
	localparam logic [11:0] STATUS_OFS    = 12'h004;
	localparam logic [11:0] PROG_OFS      = 12'h008;
	// control fields
	localparam int          CO_EN_BIT     = 0;
	localparam int          DEEP_ALLOW_BIT = 1;
	localparam int          DYN_LO_BIT    = 2;
	localparam int          DYN_HI_BIT    = 3;
	// status fields
	localparam int          CO_FLAG_BIT   = 0;
	localparam int          LOADED_BIT    = 1;
	localparam int          EXIT_BUSY_BIT = 2;
	localparam int          STATE_LO_BIT  = 4;
	localparam int          STATE_HI_BIT  = 6;
	// program-load register: write of this bit marks the program loaded
	localparam int          PROG_LOAD_BIT = 0;
	// reset values
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [1:0]  DYN_DISABLED  = 2'h0;
	// ==========================================================
	// timing
	localparam int          CLK_NS        = 50;
	localparam int          EXIT_US       = 200;
	localparam int          EXIT_CYC      = (EXIT_US * 1000) / CLK_NS;
	localparam logic [11:0] EXIT_CNT      = 12'(EXIT_CYC);
	// ==========================================================
	typedef enum logic [2:0] {
		ST_ACTIVE  = 3'b000,
		ST_CO_IDLE = 3'b001,
		ST_SAVE    = 3'b010,
		ST_DEEP    = 3'b011,
		ST_RESTORE = 3'b100
	} pstate_t;

	typedef struct packed {
		logic cdclk_pll_en;
		logic cdclk_slow_sel;
		logic display_buffer_pwr_en;
		logic pfit_pwr_en;
		logic engine_pwr_en;
		logic cfg_retain;
	} pwr_ctl_t;

	// full power at reset: pll, buffer, fitter and engine on; slow clock and retention off
	localparam pwr_ctl_t    PWR_RST       = pwr_ctl_t'(6'h2E);

	typedef struct packed {
		logic warm_rst;
		logic flr;
		logic suspend;
		logic ssr_idle;
	} async_in_t;
endpackage

//--- test/idle_power_ctrl_tb.sv
// self-checking bench for the idle power-state controller
// assumes the zero-wait apb slave and the synchronised level inputs of the design
`timescale 1ns/1ps
module idle_power_ctrl_tb;
	import idle_power_pkg::*;
	// ==========================================================
	// signals
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
	logic        clk;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        save_ctx;
	logic        restore_ctx;
	async_in_t   async_in;
	pwr_ctl_t    pwr_ctl;
	int          err_count;
	int          comparisons;
	int          i;
	row_t        rows [10];

	idle_power_ctrl uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.async_in(async_in), .pwr_ctl(pwr_ctl), .save_ctx(save_ctx), .restore_ctx(restore_ctx));

	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================================
	// helpers
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task hang(input string msg);
		err_count++;
		$display("BAD %0t wait ran out: %s", $time, msg);
		wrap_up;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	// one transfer; the request stays put until pready is seen high at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) hang("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// bounded wait until the masked power controls show a value
	task wait_pwr(input logic [5:0] mask, input logic [5:0] val);
		for (int n = 0; n < 64; n++) begin
			@(posedge clk);
			#1;
			if ((pwr_ctl & mask) === val) return;
		end
		hang("power controls");
	endtask

	// pulses stand one cycle, so every cycle is looked at
	task wait_ctx(input logic rest);
		for (int n = 0; n < 64; n++) begin
			@(posedge clk);
			#1;
			if ((rest ? restore_ctx : save_ctx) === 1'b1) return;
		end
		hang("context pulse");
	endtask

	task set_in(input logic [3:0] v);
		@(posedge clk);
		async_in <= async_in_t'(v);
	endtask

	// reset may hit mid-run as well; controls must show full power meanwhile
	task do_reset;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
		chk({26'h0, pwr_ctl}, 32'h2E, "controls in reset");
		@(posedge clk);
		rst_b <= 1'b1;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		async_in = async_in_t'(4'h0);
		err_count = 0;
		comparisons = 0;
		rows = '{'{1'b0, CTRL_OFS, 32'h0, 32'h0, 1'b0}, '{1'b0, STATUS_OFS, 32'h0, 32'h0, 1'b0},
			'{1'b0, PROG_OFS, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h00C, 32'h0, 32'h0, 1'b1},
			'{1'b1, CTRL_OFS, 32'hC, 32'h0, 1'b0}, '{1'b0, CTRL_OFS, 32'h0, 32'hC, 1'b0},
			'{1'b1, 12'h00C, 32'hFFFF_FFFF, 32'h0, 1'b1}, '{1'b1, STATUS_OFS, 32'h76, 32'h0, 1'b0},
			'{1'b0, STATUS_OFS, 32'h0, 32'h0, 1'b0}, '{1'b1, CTRL_OFS, 32'h0, 32'h0, 1'b0}};
		do_reset;
		// register access table, unmapped and read-only places among it
		for (i = 0; i < 10; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(rd, rows[i].q, "row read");
			chk({31'h0, err}, {31'h0, rows[i].e}, "row error");
		end
		$display("test table done");
		// allowed and idle, but no program yet: no entry; dynamic field kept at 00, ssr_idle line taken as set
		apb(1'b1, CTRL_OFS, 32'h1);
		set_in(4'h1);
		repeat (8) @(posedge clk);
		#1;
		chk({31'h0, pwr_ctl.cdclk_pll_en}, 32'h1, "entered unloaded");
		// program loaded: the marker write stands for the table walk, payload copy and header writes
		apb(1'b1, PROG_OFS, 32'h1);
		wait_pwr(6'h3C, 6'h10);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h13, "idle status");
		// refresh activity ends the idle state; the flag stays until cleared by zero
		set_in(4'h0);
		wait_pwr(6'h3C, 6'h2C);
		apb(1'b1, STATUS_OFS, 32'h1);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h7, "flag after one write");
		apb(1'b1, STATUS_OFS, 32'h0);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h6, "flag after zero write");
		repeat (EXIT_CYC) @(posedge clk);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h2, "exit time over");
		$display("test clock-off done");
		// re-enter, then software clears the flag and withdraws permission
		set_in(4'h1);
		wait_pwr(6'h3C, 6'h10);
		apb(1'b1, STATUS_OFS, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h0);
		wait_pwr(6'h3C, 6'h2C);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd & 32'h71, 32'h0, "flag or state after disallow");
		// deep allow wins over clock-off; state saved, then program wiped
		apb(1'b1, CTRL_OFS, 32'h3);
		wait_ctx(1'b0);
		wait_pwr(6'h23, 6'h01);
		repeat (4) @(posedge clk);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd & 32'h72, 32'h30, "deep status");
		apb(1'b1, CTRL_OFS, 32'h0);
		wait_ctx(1'b1);
		wait_pwr(6'h02, 6'h02);
		$display("test deep done");
		// warm reset, function reset and suspend each wipe the program
		for (i = 1; i < 4; i++) begin
			apb(1'b1, PROG_OFS, 32'h1);
			set_in(4'h1 << i);
			repeat (4) @(posedge clk);
			set_in(4'h0);
			apb(1'b0, STATUS_OFS, 32'h0);
			chk(rd & 32'h2, 32'h0, "program kept");
		end
		// reset while idle restores full power and clears registers
		apb(1'b1, PROG_OFS, 32'h1);
		apb(1'b1, CTRL_OFS, 32'h1);
		set_in(4'h1);
		wait_pwr(6'h20, 6'h00);
		do_reset;
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rd, 32'h0, "ctrl after reset");
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h0, "status after reset");
		$display("test resets done");
		wrap_up;
	end
endmodule // idle_power_ctrl_tb
